// file: include/acs_map.vh
/*
 * register offsets, field positions, reset values and timing counts of the
 * conversion sequencer. assumes a 32-bit APB slave, one register per word.
 */
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACS_OFF_SC1      12'h000
`define ACS_OFF_SC2      12'h004
`define ACS_OFF_CFG      12'h008
`define ACS_OFF_CVH      12'h00C
`define ACS_OFF_CVL      12'h010
`define ACS_OFF_RH       12'h014
`define ACS_OFF_RL       12'h018
`define ACS_OFF_MODE     12'h01C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACS_SC1_CONV_COMPLETE_FLAG     7
`define ACS_SC1_CONV_IRQ_ENABLE     6
`define ACS_SC1_CONT     5
`define ACS_SC2_ACT      7
`define ACS_SC2_HWTRG    6
`define ACS_SC2_CMPEN    5
`define ACS_SC2_CMPGT    4
`define ACS_CFG_LPC      7
`define ACS_CFG_LSMP     4
`define ACS_CFG_MODE10   3
`define ACS_MODE_WAIT    0
`define ACS_MODE_STOP    1

// ----------------------------------------------------------------
// reset value, channel-off code and async clock source code
// ----------------------------------------------------------------
`define ACS_SC1_RST      8'h1F
`define ACS_CH_OFF       5'h1F
`define ACS_CLK_ASYNC    2'h3

// ----------------------------------------------------------------
// timing, in converter clocks, bus cycles and ns
// ----------------------------------------------------------------
`define ACS_SMP_SHORT    8'h03
`define ACS_SMP_LONG     8'h17
`define ACS_SAR_8        8'h11
`define ACS_SAR_10       8'h14
`define ACS_XFER_BUS     5
`define ACS_ASYNC_NS     5000
`define ACS_CLK_NS       5

`endif

// file: tb/acs_sequencer_props.sv
/* port checker for the conversion sequencer.
   assumes a bind to acs_sequencer; sees its ports only. */
`timescale 1ns/100ps
module acs_seq_props (
	input wire        clk,
	input wire        reset,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        stop_mode,
	input wire        conv_irq,
	input wire        conv_active,
	input wire        converter_enable,
	input wire        async_clk_enable,
	input wire        sample_phase,
	input wire [4:0]  channel_sel_out
);
	// ----------------------------------------------------------------
	// shadow of the control fields that the bus writes
	// ----------------------------------------------------------------
	reg       conv_irq_enable_r;
	reg       hwt_r;
	reg [1:0] src_r;
	wire      wr = psel && penable && pwrite;
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			conv_irq_enable_r <= 1'b0;
			hwt_r  <= 1'b0;
			src_r  <= 2'h0;
		end else if (wr) begin
			if (paddr == 12'h000) conv_irq_enable_r <= pwdata[6];
			if (paddr == 12'h004) hwt_r <= pwdata[6];
			if (paddr == 12'h008) src_r <= pwdata[1:0];
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_IRQ: assert property (conv_irq |-> conv_irq_enable_r)
		else $error("interrupt raised while disabled");
	AST_ENA: assert property (converter_enable == (channel_sel_out != 5'h1F))
		else $error("converter enable does not follow channel");
	AST_OFF: assert property (!converter_enable |-> !conv_active)
		else $error("active while disabled");
	AST_ASYNC: assert property (async_clk_enable == (conv_active && src_r == 2'h3))
		else $error("async clock enable wrong");
	AST_ABORT: assert property (wr && paddr inside {12'h004, 12'h008, 12'h00C, 12'h010} |=> !conv_active)
		else $error("mode write did not abort");
	AST_START: assert property (wr && paddr == 12'h000 && pwdata[4:0] != 5'h1F && !hwt_r && !stop_mode
		|-> ##[1:2] conv_active)
		else $error("control write did not start");
	AST_CHOFF: assert property (wr && paddr == 12'h000 && pwdata[4:0] == 5'h1F |=> !conv_active)
		else $error("channel off did not idle");
	AST_SAMPLE: assert property ($rose(conv_active) && src_r != 2'h3 |-> ##[0:3] sample_phase)
		else $error("no sampling after start");
	// the async source first waits out its generator start-up, so sampling comes later
	AST_SAMPLE_ASYNC: assert property ($rose(conv_active) && src_r == 2'h3 |-> ##[0:1000] sample_phase)
		else $error("no sampling after async start");
	AST_STOP: assert property ($rose(stop_mode) && src_r != 2'h3 |=> !conv_active)
		else $error("stop did not abort");
	AST_RST: assert property ($fell(reset) |-> channel_sel_out == 5'h1F && !conv_active)
		else $error("not idle after reset");
endmodule

// file: tb/acs_sequencer_tb.sv
/* self-checking bench of the conversion sequencer.
   assumes acs_sequencer and acs_seq_props are compiled before it. */
`timescale 1ns/100ps
`include "acs_map.vh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module acs_sequencer_tb;
	localparam AST = 10;
	// slack covers the start and idle hand-off cycles
	localparam SLK = 3;
	localparam L10 = 43 + `ACS_XFER_BUS + SLK;
	reg        clk = 1'b0;
	reg        reset = 1'b1;
	reg        psel = 1'b0;
	reg        penable = 1'b0;
	reg        pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg        wait_mode = 1'b0;
	reg        stop_mode = 1'b0;
	reg        hw_trg = 1'b0;
	reg [10:0] conv_data = 11'h000;
	wire [31:0] prdata;
	wire       pready, pslverr, conv_irq, conv_active, converter_enable, async_clk_enable, sample_phase;
	wire [4:0] channel_sel_out;
	int        n_mismatch = 0;
	int        cmp_count = 0;
	int        n;
	reg [31:0] d;
	reg        e;
	acs_sequencer #(.ASYNC_START(AST)) i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hw_trigger_input(hw_trg), .wait_mode(wait_mode), .stop_mode(stop_mode), .conv_data(conv_data),
		.conv_irq(conv_irq), .conv_active(conv_active), .converter_enable(converter_enable),
		.async_clk_enable(async_clk_enable), .sample_phase(sample_phase), .channel_sel_out(channel_sel_out));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task xfer(input w, input [11:0] a, input [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input [11:0] a, input [31:0] wd);
		xfer(1'b1, a, wd);
	endtask
	task rd(input [11:0] a, input [31:0] x);
		xfer(1'b0, a, 32'h0);
		`CHK(d, x)
	endtask
	task idle(input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (conv_active === 1'b1);
		`CHK(n <= lim, 1'b1)
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		complete_run();
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rd(`ACS_OFF_SC1, 32'h1F);
		rd(`ACS_OFF_RH, 32'h0);
		rd(12'h020, 32'h0);
		`CHK(e, 1'b1)
		$display("test reset done");
		conv_data <= 11'h2A0;
		wr(`ACS_OFF_CFG, 32'h00);
		wr(`ACS_OFF_SC1, 32'h01);
		idle(20 + `ACS_XFER_BUS + SLK);
		rd(`ACS_OFF_SC1, 32'h81);
		rd(`ACS_OFF_RL, 32'h54);
		rd(`ACS_OFF_RH, 32'h00);
		wait_mode <= 1'b1;
		wr(`ACS_OFF_CFG, 32'h18);
		wr(`ACS_OFF_SC1, 32'h41);
		idle(L10);
		`CHK(conv_irq, 1'b1)
		rd(`ACS_OFF_RH, 32'h01);
		rd(`ACS_OFF_RL, 32'h50);
		#1;
		`CHK(conv_irq, 1'b0)
		wait_mode <= 1'b0;
		$display("test timing done");
		conv_data <= 11'h100;
		rd(`ACS_OFF_RH, 32'h01);
		wr(`ACS_OFF_SC1, 32'h01);
		cyc(60);
		`CHK(conv_active, 1'b1)
		rd(`ACS_OFF_SC1, 32'h01);
		rd(`ACS_OFF_RL, 32'h50);
		idle(L10);
		rd(`ACS_OFF_RH, 32'h00);
		rd(`ACS_OFF_RL, 32'h80);
		$display("test blocking done");
		// upper limit 0x200 against 0x080 keeps the difference 0x280
		wr(`ACS_OFF_CVH, 32'h02);
		wr(`ACS_OFF_CVL, 32'h00);
		wr(`ACS_OFF_SC2, 32'h20);
		wr(`ACS_OFF_SC1, 32'h01);
		idle(L10);
		rd(`ACS_OFF_RH, 32'h02);
		rd(`ACS_OFF_RL, 32'h80);
		rd(`ACS_OFF_RH, 32'h02);
		wr(`ACS_OFF_SC2, 32'h30);
		wr(`ACS_OFF_SC1, 32'h01);
		cyc(60);
		`CHK(conv_active, 1'b0)
		rd(`ACS_OFF_SC1, 32'h01);
		rd(`ACS_OFF_RL, 32'h80);
		$display("test compare done");
		wr(`ACS_OFF_SC2, 32'h00);
		conv_data <= 11'h7FE;
		wr(`ACS_OFF_SC1, 32'h01);
		cyc(5);
		wr(`ACS_OFF_CVL, 32'h00);
		cyc(1);
		`CHK(conv_active, 1'b0)
		wr(`ACS_OFF_SC1, 32'h01);
		cyc(5);
		stop_mode <= 1'b1;
		cyc(2);
		stop_mode <= 1'b0;
		cyc(10);
		`CHK(conv_active, 1'b0)
		rd(`ACS_OFF_RL, 32'h80);
		$display("test abort done");
		wr(`ACS_OFF_CFG, 32'h00);
		wr(`ACS_OFF_SC1, 32'h21);
		cyc(80);
		`CHK(conv_active, 1'b1)
		rd(`ACS_OFF_SC1, 32'hA1);
		rd(`ACS_OFF_RL, 32'hFF);
		wr(`ACS_OFF_SC1, 32'h1F);
		cyc(1);
		`CHK(conv_active, 1'b0)
		$display("test continuous done");
		wr(`ACS_OFF_CFG, 32'h03);
		wr(`ACS_OFF_SC1, 32'h01);
		cyc(2);
		`CHK(async_clk_enable, 1'b1)
		idle(AST + 20 + `ACS_XFER_BUS + SLK);
		`CHK(async_clk_enable, 1'b0)
		rd(`ACS_OFF_RL, 32'hFF);
		wr(`ACS_OFF_SC1, 32'h1F);
		cyc(2);
		`CHK(converter_enable, 1'b0)
		$display("test async done");
		wr(`ACS_OFF_SC2, 32'h40);
		wr(`ACS_OFF_SC1, 32'h01);
		cyc(2);
		`CHK(conv_active, 1'b0)
		hw_trg <= 1'b1;
		cyc(2);
		`CHK(conv_active, 1'b1)
		hw_trg <= 1'b0;
		idle(AST + 20 + `ACS_XFER_BUS + SLK);
		rd(`ACS_OFF_SC1, 32'h81);
		$display("test trigger done");
		wr(`ACS_OFF_SC1, 32'h01);
		cyc(5);
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		rd(`ACS_OFF_RL, 32'h00);
		rd(`ACS_OFF_SC1, 32'h1F);
		$display("test reset again done");
		complete_run();
	end
endmodule
bind acs_sequencer acs_seq_props i_props (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .stop_mode(stop_mode), .conv_irq(conv_irq),
	.conv_active(conv_active), .converter_enable(converter_enable), .async_clk_enable(async_clk_enable),
	.sample_phase(sample_phase), .channel_sel_out(channel_sel_out));

// file: verilog/acs_sequencer.v
/*
 * conversion sequencer: APB registers, sample and approximation timing,
 * compare, read blocking, abort handling and converter power control.
 * assumes the analog core delivers an 11-bit raw value on conv_data and that
 * hw_trigger_input, wait_mode and stop_mode are synchronous to clk.
 */
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "acs_map.vh"

// Notes on behaviour
// - complete means result written; flag set, interrupt if enable high then.
// - 10-bit high read without low read blocks transfer; flag clear, result lost.
// - single compare conversion with false condition ends despite blocking.
// - other blocked transfers start another conversion, even in single mode.
// - writing control 1 aborts; restarts unless channel is all ones, hardware trigger is selected or stop without async clock is on.
// - writing control 2, config or compare values aborts the conversion.
// - reset aborts and clears results; stop without async clock aborts.
// - non-reset aborts leave both result registers unchanged.
// - idle until started; async clock generator on only while active.
// - sample short or long, then approximate, then transfer result.
// - sync source short sample: 20 or 23 converter clocks plus 5 bus.
// - sync source long sample: 40 or 43 converter clocks plus 5 bus.
// - later continuous conversions take 20/23 or 40/43 converter clocks.
// - compare subtracts value; met on >= when greater set, else on <.
// - met compare stores difference without its sign bit.
// - false compare sets no flag and writes no result.
// - wait mode keeps converting; completion sets flag and interrupt.
// - in wait mode bus, bus/2 and async clocks remain usable.
// - stop without async clock aborts, idles; needs new trigger after exit.
// - converter disabled in reset or while channel is all ones.
// - 10-bit rounds to 10 bits over both registers; 8-bit low only.
module acs_sequencer #(
	parameter ASYNC_START = (`ACS_ASYNC_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS
) (
	input  wire        clk,
	input  wire        reset,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        hw_trigger_input,
	input  wire        wait_mode,
	input  wire        stop_mode,
	input  wire [10:0] conv_data,
	output wire        conv_irq,
	output wire        conv_active,
	output wire        converter_enable,
	output wire        async_clk_enable,
	output wire        sample_phase,
	output wire [4:0]  channel_sel_out
);

// ----------------------------------------------------------------
// states and registers
// ----------------------------------------------------------------
localparam [3:0] ST_IDLE  = 4'h1;
localparam [3:0] ST_START = 4'h2;
localparam [3:0] ST_RUN   = 4'h4;
localparam [3:0] ST_XFER  = 4'h8;
localparam [15:0] START_CNT = ASYNC_START;

reg  [3:0]  state_r;
reg  [3:0]  state_nxt;
reg  [7:0]  sc1_r;
reg  [7:0]  sc2_r;
reg  [7:0]  cfg_r;
reg  [7:0]  cvh_r;
reg  [7:0]  cvl_r;
reg  [7:0]  rh_r;
reg  [7:0]  rl_r;
reg         block_r;
reg         first_r;
reg         trg_d_r;
reg  [15:0] cnt_r;
reg  [15:0] cnt_nxt;
reg  [1:0]  div_r;
reg  [7:0]  converter_clock_r;
reg         sample_r;
reg  [31:0] rd_val;

wire        wr = psel & penable & pwrite;
wire        rd = psel & penable & ~pwrite;
wire        wr_sc1 = wr & (paddr == `ACS_OFF_SC1);
wire        wr_mode = wr & ((paddr == `ACS_OFF_SC2) | (paddr == `ACS_OFF_CFG) |
                            (paddr == `ACS_OFF_CVH) | (paddr == `ACS_OFF_CVL));
wire        ch_off = (sc1_r[4:0] == `ACS_CH_OFF);
wire        async_sel = (cfg_r[1:0] == `ACS_CLK_ASYNC);
wire        mode10 = cfg_r[`ACS_CFG_MODE10];
wire        cmp_en = sc2_r[`ACS_SC2_CMPEN];
wire        cmp_gt = sc2_r[`ACS_SC2_CMPGT];
wire        cont = sc1_r[`ACS_SC1_CONT];
wire        hw_mode = sc2_r[`ACS_SC2_HWTRG];
wire        busy = (state_r != ST_IDLE);
wire        stop_abort = stop_mode & ~async_sel;
wire        abort = wr_sc1 | wr_mode | stop_abort;
wire        hw_edge = hw_mode & hw_trigger_input & ~trg_d_r & ~busy;

// ----------------------------------------------------------------
// converter clock divider: clock_source_sel value 1 (bus/2) adds a /2 stage
// ----------------------------------------------------------------
wire [3:0]  div_lim = ((4'h1 << cfg_r[6:5]) << (cfg_r[1:0] == 2'h1)) - 4'h1;
wire        converter_clock_tick = (converter_clock_r[3:0] == div_lim);

// ----------------------------------------------------------------
// rounding and compare
// ----------------------------------------------------------------
wire [10:0] rnd10 = (conv_data[10:1] == 10'h3FF) ? 11'h3FF : ({1'b0, conv_data[10:1]} + {10'h000, conv_data[0]});
wire [10:0] rnd8 = (conv_data[10:3] == 8'hFF) ? 11'h0FF : ({3'h0, conv_data[10:3]} + {10'h000, conv_data[2]});
wire [9:0]  res = mode10 ? rnd10[9:0] : {2'h0, rnd8[7:0]};
wire [9:0]  cmp_val = mode10 ? {cvh_r[1:0], cvl_r} : {2'h0, cvl_r};
wire [10:0] diff = {1'b0, res} - {1'b0, cmp_val};
wire        cmp_ok = ~cmp_en | (cmp_gt ? ~diff[10] : diff[10]);
wire [9:0]  store = cmp_en ? diff[9:0] : res;
wire        blocked = block_r & mode10;
wire        do_store = cmp_ok & ~blocked;
wire        again = cmp_ok ? (blocked | cont) : (cont | blocked & ~(~cont & cmp_en));

// sample length and approximation length in converter clocks
wire [7:0]  smp_len = sc2_dummy_len(cfg_r[`ACS_CFG_LSMP]);
wire [7:0]  sar_len = mode10 ? `ACS_SAR_10 : `ACS_SAR_8;

function [7:0] sc2_dummy_len;
	input lsmp;
	begin
		sc2_dummy_len = lsmp ? `ACS_SMP_LONG : `ACS_SMP_SHORT;
	end
endfunction

// ----------------------------------------------------------------
// sequence: start-up, sample plus approximation, transfer
// ----------------------------------------------------------------
always @* begin
	state_nxt = state_r;
	cnt_nxt = cnt_r;
	case (state_r)
		ST_IDLE: begin
			if ((wr_sc1 & ~pwdata[4] | wr_sc1 & (pwdata[4:0] != `ACS_CH_OFF)) & ~hw_mode & ~stop_abort) begin
				state_nxt = ST_START;
				cnt_nxt = 16'h0000;
			end else if (hw_edge & ~ch_off & ~abort) begin
				state_nxt = ST_START;
				cnt_nxt = 16'h0000;
			end
		end
		ST_START: begin
			// async generator startup on the first conversion only
			if (~async_sel | ~first_r | cnt_r >= START_CNT) begin
				state_nxt = ST_RUN;
				cnt_nxt = 16'h0000;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
		ST_RUN: begin
			if (converter_clock_tick) begin
				if (cnt_r[7:0] == smp_len + sar_len - 8'h01) begin
					state_nxt = ST_XFER;
					cnt_nxt = 16'h0000;
				end else begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
		end
		ST_XFER: begin
			// bus-side transfer, counted in bus cycles
			if (cnt_r == `ACS_XFER_BUS - 1) begin
				state_nxt = again ? ST_RUN : ST_IDLE;
				cnt_nxt = 16'h0000;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
		default: begin
			state_nxt = ST_IDLE;
			cnt_nxt = 16'h0000;
		end
	endcase
	// an abort restarts only on a control 1 write with a channel, no hardware trigger and no stop abort, else idles; a start from idle is taken above
	if (abort & busy) begin
		state_nxt = (wr_sc1 & (pwdata[4:0] != `ACS_CH_OFF) & ~hw_mode & ~stop_abort) ? ST_START : ST_IDLE;
		cnt_nxt = 16'h0000;
	end
end

wire xfer_done = (state_r == ST_XFER) & (cnt_r == `ACS_XFER_BUS - 1) & ~abort;

always @(posedge clk or posedge reset) begin
	if (reset) begin
		state_r <= ST_IDLE;
		cnt_r <= 16'h0000;
		converter_clock_r <= 8'h00;
		sample_r <= 1'b0;
		first_r <= 1'b1;
		trg_d_r <= 1'b0;
	end else begin
		state_r <= state_nxt;
		cnt_r <= cnt_nxt;
		trg_d_r <= hw_trigger_input;
		converter_clock_r <= (state_r != ST_RUN | converter_clock_tick) ? 8'h00 : converter_clock_r + 8'h01;
		sample_r <= (state_nxt == ST_RUN) & (cnt_nxt[7:0] < smp_len);
		if (state_r == ST_IDLE)
			first_r <= 1'b1;
		else if (state_r == ST_RUN)
			first_r <= 1'b0;
	end
end

// ----------------------------------------------------------------
// registers; a completion set wins over the clearing low-result read
// ----------------------------------------------------------------
always @(posedge clk or posedge reset) begin
	if (reset) begin
		sc1_r <= `ACS_SC1_RST;
		sc2_r <= 8'h00;
		cfg_r <= 8'h00;
		cvh_r <= 8'h00;
		cvl_r <= 8'h00;
		rh_r <= 8'h00;
		rl_r <= 8'h00;
		block_r <= 1'b0;
	end else begin
		if (wr_sc1)
			sc1_r[6:0] <= pwdata[6:0];
		if (wr & (paddr == `ACS_OFF_SC2))
			sc2_r[6:4] <= pwdata[6:4];
		if (wr & (paddr == `ACS_OFF_CFG))
			cfg_r <= pwdata[7:0];
		if (wr & (paddr == `ACS_OFF_CVH))
			cvh_r <= {6'h00, pwdata[1:0]};
		if (wr & (paddr == `ACS_OFF_CVL))
			cvl_r <= pwdata[7:0];
		// flag clears by writing control 1 or reading the low result
		if (xfer_done & do_store)
			sc1_r[`ACS_SC1_CONV_COMPLETE_FLAG] <= 1'b1;
		else if (wr_sc1 | rd & (paddr == `ACS_OFF_RL))
			sc1_r[`ACS_SC1_CONV_COMPLETE_FLAG] <= 1'b0;
		if (xfer_done & do_store) begin
			rh_r <= {6'h00, store[9:8]};
			rl_r <= store[7:0];
		end
		if (rd & (paddr == `ACS_OFF_RH) & mode10)
			block_r <= 1'b1;
		else if (rd & (paddr == `ACS_OFF_RL))
			block_r <= 1'b0;
	end
end

// ----------------------------------------------------------------
// APB read side; zero-wait, unmapped offsets read zero and error
// ----------------------------------------------------------------
always @* begin
	rd_val = 32'h00000000;
	case (paddr)
		`ACS_OFF_SC1:  rd_val = {24'h000000, sc1_r};
		`ACS_OFF_SC2:  rd_val = {24'h000000, busy, sc2_r[6:0]};
		`ACS_OFF_CFG:  rd_val = {24'h000000, cfg_r};
		`ACS_OFF_CVH:  rd_val = {24'h000000, cvh_r};
		`ACS_OFF_CVL:  rd_val = {24'h000000, cvl_r};
		`ACS_OFF_RH:   rd_val = {24'h000000, rh_r};
		`ACS_OFF_RL:   rd_val = {24'h000000, rl_r};
		`ACS_OFF_MODE: rd_val = {30'h00000000, stop_mode, wait_mode};
		default:       rd_val = 32'h00000000;
	endcase
end

always @(posedge clk or posedge reset) begin
	if (reset)
		prdata <= 32'h00000000;
	else if (psel & ~penable & ~pwrite)
		prdata <= rd_val;
end

assign pready = 1'b1;
assign pslverr = psel & penable & (paddr > `ACS_OFF_MODE | paddr[1:0] != 2'h0);
assign conv_irq = sc1_r[`ACS_SC1_CONV_COMPLETE_FLAG] & sc1_r[`ACS_SC1_CONV_IRQ_ENABLE];
assign conv_active = busy;
assign converter_enable = ~ch_off;
assign async_clk_enable = busy & async_sel;
assign sample_phase = sample_r;
assign channel_sel_out = sc1_r[4:0];

endmodule
